// >>> shared/pac_map.svh
// Constant map of the packed character codec: widths, field positions, pad values.
`ifndef PAC_MAP_SVH
`define PAC_MAP_SVH
`define PAC_CHAR_W 8
`define PAC_CODE_W 6
`define PAC_GROUP_CHARS 4
`define PAC_GROUP_BYTES 3
`define PAC_BIT5 5
`define PAC_BIT6 6
`define PAC_BIT7 7
`define PAC_SPACE_CHAR 8'h20
`define PAC_SPACE_CODE 6'h20
`define PAC_ZERO_CHAR 8'h00
`define PAC_ZERO_WORD 24'h000000
`define PAC_ZERO_IDX 2'h0
`define PAC_LAST_CHAR 2'h3
`define PAC_LAST_BYTE 2'h2
`endif

// >>> shared/pac_pkg.sv
// Types shared by the packed character codec files.
package pac_pkg;
  // Codec direction.
  typedef enum logic [0:0] {
    PAC_PACK = 1'b0,
    PAC_UNPACK = 1'b1
  } pac_dir_t;
  // Group engine states.
  typedef enum logic [1:0] {
    PAC_S_FILL = 2'b00,
    PAC_S_EMIT = 2'b01
  } pac_state_t;
endpackage

// >>> rtl/pac_char_unit.sv
// One character lane: six-bit code extraction and eight-bit character rebuild.
`timescale 1ns/10ps
`include "pac_map.svh"
module pac_char_unit
  import pac_pkg::*;
(
  // Lane inputs.
  input wire logic [7:0] char_in,
  input wire logic [5:0] code_in,
  // Lane outputs.
  output logic [5:0] code_out,
  output logic [7:0] char_out
);
  // The top two bits are discarded; only the low six survive.
  assign code_out = char_in[`PAC_CODE_W-1:0];
  // Bit 7 is zero, bit 6 is the complement of bit 5, the rest is the code.
  // This maps codes 00-1F to '@'..'_' and 20-3F to space..'?'.
  assign char_out = {1'b0, ~code_in[`PAC_BIT5], code_in};
endmodule // pac_char_unit

// >>> rtl/pac_codec.sv
// Packed six-bit character codec: packs and unpacks strings a group at a time.
`timescale 1ns/10ps
`include "pac_map.svh"
module pac_codec
  import pac_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Direction, held steady for a whole string.
  input wire logic dir,
  // Input stream.
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  // Output stream.
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready
);
  // Group engine state.
  pac_state_t state;
  // Assembled 24-bit group word.
  logic [23:0] word;
  // Count of symbols taken into or sent from the group.
  logic [1:0] idx;
  // The group ends the string.
  logic grp_last;
  // Direction latched for the group in flight.
  logic grp_dir;
  // Lane wiring for four lanes; only lane 0 has a character unit.
  logic [7:0] lane_char [4];
  logic [5:0] lane_code [4];
  logic [5:0] lane_in_code;
  logic [7:0] lane_out_char;
  // Input symbol accepted this cycle.
  logic take;
  // Output symbol accepted this cycle.
  logic give;
  // Symbol counts that end the fill and emit phases.
  logic [1:0] fill_end;
  logic [1:0] emit_end;

  // Lane 0 serves the incoming character, the others are unused wires.
  pac_char_unit u_lane
  (
    .char_in(in_data),
    .code_in(lane_in_code),
    .code_out(lane_code[0]),
    .char_out(lane_out_char)
  );
  assign lane_char[0] = in_data;

  // In unpack mode the next code to rebuild is the top six bits of the word.
  assign lane_in_code = word[23:18];

  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;
  assign fill_end = (dir == PAC_PACK) ? `PAC_LAST_CHAR : `PAC_LAST_BYTE;
  assign emit_end = (grp_dir == PAC_PACK) ? `PAC_LAST_BYTE : `PAC_LAST_CHAR;

  // Group engine: fill a group from the input, then emit it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= PAC_S_FILL;
      word <= `PAC_ZERO_WORD;
      idx <= `PAC_ZERO_IDX;
      grp_last <= 1'b0;
      grp_dir <= PAC_PACK;
    end
    else
    begin
      case (state)
        PAC_S_FILL:
        begin
          if (grp_last)
          begin
            // Padding phase: the string ended mid group, append spaces.
            word <= {word[17:0], `PAC_SPACE_CODE};
            if (idx == `PAC_LAST_CHAR)
            begin
              idx <= `PAC_ZERO_IDX;
              state <= PAC_S_EMIT;
            end
            else
            begin
              idx <= idx + 2'h1;
            end
          end
          else if (take)
          begin
            grp_dir <= pac_dir_t'(dir);
            if (dir == PAC_PACK)
            begin
              // Shift in the six-bit code, first character ends on top.
              word <= {word[17:0], lane_code[0]};
            end
            else
            begin
              // Shift in a whole byte, first byte ends on top.
              word <= {word[15:0], in_data};
            end
            if (idx == fill_end)
            begin
              idx <= `PAC_ZERO_IDX;
              grp_last <= in_last;
              state <= PAC_S_EMIT;
            end
            else
            begin
              idx <= idx + 2'h1;
              // A packing string that ends short goes to the padding phase.
              grp_last <= in_last && (dir == PAC_PACK);
            end
          end
        end
        PAC_S_EMIT:
        begin
          if (give)
          begin
            // Step to the next symbol, most significant first.
            if (grp_dir == PAC_PACK)
            begin
              word <= {word[15:0], 8'h00};
            end
            else
            begin
              word <= {word[17:0], 6'h00};
            end
            if (idx == emit_end)
            begin
              // Group finished; carry on with the next one.
              idx <= `PAC_ZERO_IDX;
              grp_last <= 1'b0;
              state <= PAC_S_FILL;
            end
            else
            begin
              idx <= idx + 2'h1;
            end
          end
        end
        default:
        begin
          state <= PAC_S_FILL;
          idx <= `PAC_ZERO_IDX;
        end
      endcase
    end
  end

  // Next output register values, computed from the current state and this cycle's handshakes.
  logic next_out_valid;
  logic [7:0] next_out_data;
  logic next_out_last;
  logic next_in_ready;
  always_comb
  begin
    next_out_valid = out_valid;
    next_out_data = out_data;
    next_out_last = out_last;
    next_in_ready = in_ready;
    if (state == PAC_S_FILL)
    begin
      next_out_valid = 1'b0;
      next_in_ready = !grp_last && !(take && idx == fill_end);
      if (!grp_last && take && idx == fill_end)
      begin
        next_in_ready = 1'b0;
      end
      if (grp_last && idx == `PAC_LAST_CHAR)
      begin
        next_in_ready = 1'b0;
      end
    end
    else
    begin
      next_in_ready = 1'b0;
      if (give && idx == emit_end)
      begin
        next_out_valid = 1'b0;
        next_in_ready = 1'b1;
      end
    end
    // Arm the output when the emit state is entered or advances.
    if (state == PAC_S_EMIT && !out_valid && !(give))
    begin
      next_out_valid = 1'b1;
    end
    if (state == PAC_S_EMIT && give && idx != emit_end)
    begin
      next_out_valid = 1'b0;
    end
    next_out_data = (grp_dir == PAC_PACK) ? word[23:16] : lane_out_char;
    next_out_last = grp_last && (idx == emit_end);
  end

  // Output registers: one symbol is presented at a time.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= `PAC_ZERO_CHAR;
      out_last <= 1'b0;
      in_ready <= 1'b0;
    end
    else
    begin
      out_valid <= next_out_valid;
      if (!out_valid)
      begin
        out_data <= next_out_data;
        out_last <= next_out_last;
      end
      in_ready <= next_in_ready;
    end
  end

  // Unpacked characters always have bit 7 clear.
  a_unpack_bit7: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && grp_dir == PAC_UNPACK) |-> !out_data[`PAC_BIT7])
    else $error("Unpacked character has bit 7 set");
  // Unpacked bit 6 is the inverse of bit 5.
  a_unpack_bit6: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && grp_dir == PAC_UNPACK) |-> (out_data[6] != out_data[5]))
    else $error("Unpacked bit 6 not inverse of bit 5");
  // The output holds while stalled.
  a_out_hold: assert property (@(posedge mclk) disable iff (rst)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("Output changed while stalled");
  // Input and output are never active together.
  a_no_overlap: assert property (@(posedge mclk) disable iff (rst)
    !(in_ready && out_valid))
    else $error("Input and output open together");
  // A padded group starts emitting within six cycles.
  a_pad_bound: assert property (@(posedge mclk) disable iff (rst)
    (state == PAC_S_FILL && grp_last) |-> ##[1:6] out_valid)
    else $error("Padding did not finish");
  // Pack path keeps only the low six bits.
  a_pack_trunc: assert property (@(posedge mclk) disable iff (rst)
    (take && dir == PAC_PACK) |=> (word[5:0] == $past(in_data[5:0])))
    else $error("Packed code is not the low six bits");
  // Unpack path shifts a whole byte.
  a_unpack_load: assert property (@(posedge mclk) disable iff (rst)
    (take && dir == PAC_UNPACK) |=> (word[7:0] == $past(in_data)))
    else $error("Unpack byte not loaded");
  // An emitting group returns to fill once drained.
  a_group_loop: assert property (@(posedge mclk) disable iff (rst)
    (state == PAC_S_EMIT && give && idx == emit_end) |=> state == PAC_S_FILL)
    else $error("Group did not restart");
  c_pack: cover property (@(posedge mclk) disable iff (rst)
    give && out_last && grp_dir == PAC_PACK);
  c_unpack: cover property (@(posedge mclk) disable iff (rst)
    give && out_last && grp_dir == PAC_UNPACK);
  c_pad: cover property (@(posedge mclk) disable iff (rst)
    state == PAC_S_FILL && grp_last && idx == `PAC_ZERO_IDX);
endmodule // pac_codec

// >>> tb/pac_sink.sv
// Output stream sink that stalls on a pseudo random pattern.
`timescale 1ns/10ps
module pac_sink (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // High to throttle the stream.
  input wire logic slow,
  // Ready towards the codec.
  output logic out_ready
);
  // Pattern state for the stall choice.
  logic [7:0] lfsr;
  // Ready moves only at falling edges, so it never races the codec's sampling edge.
  always @(negedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lfsr <= 8'hA5;
      out_ready <= 1'b0;
    end
    else
    begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      out_ready <= !slow || lfsr[0];
    end
  end
endmodule // pac_sink

// >>> tb/testbench.sv
// Self-checking bench: drives strings both ways and compares with a queue model.
`timescale 1ns/10ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, g, x); end end
module testbench;
  import pac_pkg::*;
  // Stimulus and observed signals.
  logic mclk = 0, rst = 1, dir = 0, in_valid = 0, in_last = 0, slow = 0;
  logic [7:0] in_data = 8'h00, out_data, b;
  logic in_ready, out_valid, out_last, out_ready;
  int n_mismatch = 0, samples_checked = 0;
  logic [31:0] rng = 32'h0000002C;
  logic [7:0] str[$];
  logic [8:0] expq[$], e;
  always #2.5 mclk = ~mclk;
  pac_codec DUT (.mclk(mclk), .rst(rst), .dir(dir), .in_valid(in_valid), .in_data(in_data),
    .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready));
  pac_sink SINK (.mclk(mclk), .rst(rst), .slow(slow), .out_ready(out_ready));
  // Random byte from the xorshift generator.
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  // Every taken output symbol is compared with the model's next one.
  always @(posedge mclk)
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      e = (expq.size() > 0) ? expq.pop_front() : 9'h1FF;
      `CHK({out_last, out_data}, e)
    end
  // Builds the expected stream of str, sends it, and waits for the drain.
  task automatic play(input pac_dir_t d);
    logic [23:0] w;
    logic [5:0] c;
    int i, j, k, n;
    @(negedge mclk);
    dir = d;
    n = str.size();
    if (d == PAC_PACK)
      for (i = 0; i < n; i += 4)
      begin
        for (j = 0; j < 4; j++)
          w = {w[17:0], (i + j < n) ? str[i + j][5:0] : 6'h20};
        for (j = 0; j < 3; j++)
          expq.push_back({i + 4 >= n && j == 2, w[23 - 8 * j -: 8]});
      end
    else
      for (i = 0; i < n; i += 3)
      begin
        w = {str[i], str[i + 1], str[i + 2]};
        for (j = 0; j < 4; j++)
        begin
          c = w[23 - 6 * j -: 6];
          expq.push_back({i + 3 >= n && j == 3, 1'b0, ~c[5], c});
        end
      end
    for (i = 0; i < n; i++)
    begin
      @(negedge mclk);
      in_valid = 1;
      in_data = str[i];
      in_last = (i == n - 1);
      k = 0;
      do @(posedge mclk); while (in_ready !== 1'b1 && ++k < 300);
      `CHK(k < 300, 1'b1)
    end
    @(negedge mclk);
    in_valid = 0;
    for (k = 0; k < 600 && expq.size() > 0; k++) @(posedge mclk);
    `CHK(expq.size(), 0)
    str.delete();
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial
  begin
    #200000;
    n_mismatch++;
    conclude();
  end
  // Main sequence of tests.
  initial
  begin
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst = 0;
    str = '{8'h20, 8'h20, 8'h20, 8'h20};
    play(PAC_PACK);
    $display("test four spaces done");
    for (int t = 1; t < 14; t++)
    begin
      slow = t[0];
      repeat (t) str.push_back(rnd());
      play(PAC_PACK);
    end
    $display("test random pack done");
    for (int g = 0; g < 64; g += 4)
    begin
      b = 8'(g);
      str.push_back({b[5:0], b[5:4]});
      str.push_back({b[3:0] + 4'h1, b[5:2]});
      str.push_back({b[1:0] | 2'h2, b[5:0] + 6'h3});
    end
    play(PAC_UNPACK);
    $display("test code table done");
    for (int t = 0; t < 10; t++)
    begin
      slow = t[0];
      repeat (3 * (1 + t % 4)) str.push_back(rnd());
      play(PAC_UNPACK);
    end
    $display("test random unpack done");
    conclude();
  end
endmodule // testbench
